/* File: design/tpp_defs.svh */
// Register offsets, field positions, reset values and timing figures.
`ifndef TPP_DEFS_SVH
`define TPP_DEFS_SVH

`define TPP_ADDR_W          8
`define TPP_OFF_CTRL        8'h00
`define TPP_OFF_THRESH      8'h04
`define TPP_OFF_STATUS      8'h08
`define TPP_OFF_INT_STAT    8'h0c
`define TPP_OFF_INT_MASK    8'h10

`define TPP_CTRL_STATE_LSB  0
`define TPP_CTRL_AUDIO_DIS  4
`define TPP_CTRL_SPIN_LSB   8
`define TPP_CTRL_RST        32'h0000_0000
`define TPP_CTRL_MASK       32'h0000_0717

`define TPP_THRESH_RST      32'h005f_5546
`define TPP_THRESH_MASK     32'h00ff_ffff
`define TPP_HYST_DEG        9'h005
`define TPP_INT_BITS        5
`define TPP_INT_RST         5'h00

`define TPP_CLK_MHZ         50
`define TPP_SAMPLE_MS       100
`define TPP_THROTTLE_US     20
`define TPP_CLKRUN_IDLE_NS  640
`define TPP_SPIN_TICK_MS    1000

`endif

/* File: design/tpp_pkg.sv */
// Types shared by the thermal and power policy block.
package tpp_pkg;

  typedef enum logic [2:0] {
    TPP_PS_ON      = 3'h0,
    TPP_PS_STANDBY = 3'h1,
    TPP_PS_SUSPEND = 3'h2,
    TPP_PS_STATIC  = 3'h3,
    TPP_PS_OFF     = 3'h4
  } tpp_pstate_t;

  typedef enum logic [3:0] {
    TPP_TH_NORMAL   = 4'h1,
    TPP_TH_MANAGED  = 4'h2,
    TPP_TH_THROTTLE = 4'h4,
    TPP_TH_CRITICAL = 4'h8
  } tpp_therm_t;

  typedef enum logic [2:0] {
    TPP_CR_RUN     = 3'h1,
    TPP_CR_RELEASE = 3'h2,
    TPP_CR_STOPPED = 3'h4
  } tpp_clkrun_t;

endpackage

/* File: design/tpp_ctl_if.sv */
// Signals between the policy top and its thermal and idle-timer engines.
`timescale 1ns/1ns
interface tpp_ctl_if;
  logic [7:0]          temp;
  logic [7:0]          thr_low;
  logic [7:0]          thr_mid;
  logic [7:0]          thr_high;
  tpp_pkg::tpp_therm_t therm_state;
  logic                fan_on;
  logic                stop_clk;
  logic                ev_manage;
  logic                ev_throttle;
  logic                ev_critical;
  logic                drive_active;
  logic [2:0]          spin_sel;
  logic                spun_down;
  logic                ev_spin;

  modport top (
    output temp, thr_low, thr_mid, thr_high, drive_active, spin_sel,
    input  therm_state, fan_on, stop_clk, ev_manage, ev_throttle,
    input  ev_critical, spun_down, ev_spin
  );
  modport therm (
    input  temp, thr_low, thr_mid, thr_high,
    output therm_state, fan_on, stop_clk, ev_manage, ev_throttle,
    output ev_critical
  );
  modport idle (
    input  drive_active, spin_sel,
    output spun_down, ev_spin
  );
endinterface

/* File: design/tpp_thermal.sv */
// Periodic temperature sampling, threshold ladder and clock throttling.
`timescale 1ns/1ns
`include "tpp_defs.svh"
module tpp_thermal #(
  parameter int unsigned SAMPLE_CYCLES = 5000000,
  parameter int unsigned THROTTLE_HALF = 500
) (
  input wire logic aclk,     // System clock.
  input wire logic aresetn,  // Synchronous reset, active low.
  tpp_ctl_if.therm ctl       // Thresholds in, thermal state out.
);

  logic [31:0]         sample_cnt;
  logic                tick;
  logic [7:0]          sample;
  tpp_pkg::tpp_therm_t state;
  tpp_pkg::tpp_therm_t next_state;
  logic [15:0]         thr_cnt;
  logic                thr_phase;

  assign tick = (sample_cnt == 32'(SAMPLE_CYCLES - 1));

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_cnt <= 32'h0000_0000;
    end else if (tick) begin
      sample_cnt <= 32'h0000_0000;
    end else begin
      sample_cnt <= sample_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample <= 8'h00;
    end else if (tick) begin
      sample <= ctl.temp;
    end
  end

  // ----------------------------------------------------------------
  // Threshold ladder
  // ----------------------------------------------------------------
  // The highest crossed level wins; only the bottom step has hysteresis.
  always_comb begin
    next_state = state;
    if (sample > ctl.thr_high) begin
      next_state = tpp_pkg::TPP_TH_CRITICAL;
    end else if (sample > ctl.thr_mid) begin
      next_state = tpp_pkg::TPP_TH_THROTTLE;
    end else if (sample >= ctl.thr_low) begin
      next_state = tpp_pkg::TPP_TH_MANAGED;
    end else if ({1'b0, sample} + `TPP_HYST_DEG <= {1'b0, ctl.thr_low}) begin
      next_state = tpp_pkg::TPP_TH_NORMAL;
    end else if (state != tpp_pkg::TPP_TH_NORMAL) begin
      next_state = tpp_pkg::TPP_TH_MANAGED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tpp_pkg::TPP_TH_NORMAL;
    end else if (tick) begin
      state <= next_state;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl.ev_manage   <= 1'b0;
      ctl.ev_throttle <= 1'b0;
      ctl.ev_critical <= 1'b0;
    end else begin
      ctl.ev_manage   <= tick && state == tpp_pkg::TPP_TH_NORMAL &&
                         next_state != tpp_pkg::TPP_TH_NORMAL;
      ctl.ev_throttle <= tick && state != tpp_pkg::TPP_TH_THROTTLE &&
                         next_state == tpp_pkg::TPP_TH_THROTTLE;
      ctl.ev_critical <= tick && state != tpp_pkg::TPP_TH_CRITICAL &&
                         next_state == tpp_pkg::TPP_TH_CRITICAL;
    end
  end

  // ----------------------------------------------------------------
  // Half-duty throttle
  // ----------------------------------------------------------------
  // Stop-clock is high for half of each period, so the core runs at half.
  always_ff @(posedge aclk) begin
    if (!aresetn || state == tpp_pkg::TPP_TH_NORMAL ||
        state == tpp_pkg::TPP_TH_MANAGED) begin
      thr_cnt   <= 16'h0000;
      thr_phase <= 1'b0;
    end else if (thr_cnt == 16'(THROTTLE_HALF - 1)) begin
      thr_cnt   <= 16'h0000;
      thr_phase <= ~thr_phase;
    end else begin
      thr_cnt <= thr_cnt + 16'h0001;
    end
  end

  assign ctl.therm_state = state;
  assign ctl.fan_on      = (state != tpp_pkg::TPP_TH_NORMAL);
  assign ctl.stop_clk    = thr_phase;

endmodule

/* File: design/tpp_idle_timer.sv */
// Drive inactivity timer with selectable spin-down timeout.
`timescale 1ns/1ns
`include "tpp_defs.svh"
module tpp_idle_timer #(
  parameter int unsigned TICK_CYCLES = 50000000
) (
  input wire logic aclk,     // System clock.
  input wire logic aresetn,  // Synchronous reset, active low.
  tpp_ctl_if.idle  ctl       // Activity and select in, spin-down out.
);

  logic [31:0] pre_cnt;
  logic        sec_tick;
  logic [11:0] sec_cnt;

  // Timeout in seconds for each select code; code zero disables.
  function automatic logic [11:0] timeout_s(input logic [2:0] sel);
    case (sel)
      3'h1:    timeout_s = 12'h03c;
      3'h2:    timeout_s = 12'h078;
      3'h3:    timeout_s = 12'h12c;
      3'h4:    timeout_s = 12'h258;
      3'h5:    timeout_s = 12'h384;
      3'h6:    timeout_s = 12'h4b0;
      3'h7:    timeout_s = 12'h708;
      default: timeout_s = 12'h000;
    endcase
  endfunction

  assign sec_tick = (pre_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.drive_active || sec_tick) begin
      pre_cnt <= 32'h0000_0000;
    end else begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt       <= 12'h000;
      ctl.spun_down <= 1'b0;
      ctl.ev_spin   <= 1'b0;
    end else begin
      ctl.ev_spin <= 1'b0;
      if (ctl.drive_active || ctl.spin_sel == 3'h0) begin
        sec_cnt       <= 12'h000;
        ctl.spun_down <= 1'b0;
      end else if (sec_tick && !ctl.spun_down) begin
        if (sec_cnt + 12'h001 >= timeout_s(ctl.spin_sel)) begin
          ctl.spun_down <= 1'b1;
          ctl.ev_spin   <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + 12'h001;
        end
      end
    end
  end

endmodule

/* File: design/tpp_top.sv */
// Thermal and power policy top: AXI4-Lite registers and power gating.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "tpp_defs.svh"

// What this block does
// - Hold three thresholds; compare temperature against each.
// - At or above lowest threshold: manage heat, fan on.
// - Full speed only five degrees below lowest.
// - Above second threshold: throttle core to half speed.
// - Above highest threshold: force critical suspend.
// - Cache power off in Off and Suspend.
// - Stop PCI clock when idle; restart on activity.
// - Drive and bay power off in Standby.
// - Idle timer spins drive down; disabled or preset.
// - Super I/O low power in Standby, Static Suspend.
// - Audio low power in Standby, Suspend, or disabled.
// - Amplifier powerdown follows audio low power.
module tpp_top #(
  parameter int unsigned SAMPLE_CYCLES = `TPP_SAMPLE_MS * 1000 * `TPP_CLK_MHZ,
  parameter int unsigned SPIN_TICK_CYCLES =
    `TPP_SPIN_TICK_MS * 1000 * `TPP_CLK_MHZ
) (
  input  wire logic        aclk,                  // System clock, 50 MHz.
  input  wire logic        aresetn,               // Sync reset, active low.
  input  wire logic [7:0]  s_axi_awaddr,          // Write address.
  input  wire logic [2:0]  s_axi_awprot,          // Write protection.
  input  wire logic        s_axi_awvalid,         // Write address valid.
  output logic             s_axi_awready,         // Write address ready.
  input  wire logic [31:0] s_axi_wdata,           // Write data.
  input  wire logic [3:0]  s_axi_wstrb,           // Write byte strobes.
  input  wire logic        s_axi_wvalid,          // Write data valid.
  output logic             s_axi_wready,          // Write data ready.
  output logic [1:0]       s_axi_bresp,           // Write response.
  output logic             s_axi_bvalid,          // Write response valid.
  input  wire logic        s_axi_bready,          // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,          // Read address.
  input  wire logic [2:0]  s_axi_arprot,          // Read protection.
  input  wire logic        s_axi_arvalid,         // Read address valid.
  output logic             s_axi_arready,         // Read address ready.
  output logic [31:0]      s_axi_rdata,           // Read data.
  output logic [1:0]       s_axi_rresp,           // Read response.
  output logic             s_axi_rvalid,          // Read data valid.
  input  wire logic        s_axi_rready,          // Read data ready.
  input  wire logic [7:0]  processor_temperature_sense, // Digitized temp.
  input  wire logic        drive_activity,        // Drive access seen.
  input  wire logic        pci_activity,          // PCI bus busy.
  input  wire logic        clkrun_n_in,           // Clock-run pin level.
  output logic             clkrun_n_out,          // Clock-run drive value.
  output logic             clkrun_n_oe,           // Clock-run drive enable.
  output logic             pci_clk_enable,        // PCI clock running.
  output logic             fan_enable,            // Cooling fan on.
  output logic             stop_clock_request,    // Core stop-clock.
  output logic             critical_suspend_req,  // Force suspend.
  output logic             l2_cache_power_en,     // Cache power on.
  output logic             hdd_power_en,          // Hard drive power.
  output logic             bay_power_en,          // Bay device power.
  output logic             hdd_spin_down,         // Drive spun down.
  output logic             super_io_low_power,    // Super I/O low power.
  output logic             audio_low_power,       // Audio low power.
  output logic             general_output_3,      // Amplifier control bit.
  output logic             amp_powerdown,         // Amplifier powerdown.
  output logic             irq                    // Interrupt, active high.
);

  localparam int unsigned THROTTLE_HALF =
    `TPP_THROTTLE_US * `TPP_CLK_MHZ / 2;
  localparam int unsigned CLKRUN_IDLE_CYC =
    (`TPP_CLKRUN_IDLE_NS * `TPP_CLK_MHZ + 999) / 1000;

  tpp_ctl_if ctl ();

  logic [31:0]                   ctrl;
  logic [31:0]                   thresh;
  logic [`TPP_INT_BITS-1:0]      int_stat;
  logic [`TPP_INT_BITS-1:0]      int_mask;
  logic [`TPP_INT_BITS-1:0]      int_set;
  logic [`TPP_INT_BITS-1:0]      int_clr;
  logic                          aw_held;
  logic                          w_held;
  logic [7:0]                    aw_addr;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;
  logic                          wr_go;
  tpp_pkg::tpp_pstate_t          pstate;
  tpp_pkg::tpp_clkrun_t          cr_state;
  logic [7:0]                    idle_cnt;
  logic                          ev_pci_stop;
  logic                          audio_off;

  // Expands byte strobes into a bit mask of the written lanes.
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are taken independently and joined here, so the
  // master may present them in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == `TPP_OFF_CTRL || aw_addr == `TPP_OFF_THRESH ||
          aw_addr == `TPP_OFF_STATUS || aw_addr == `TPP_OFF_INT_STAT ||
          aw_addr == `TPP_OFF_INT_MASK) begin
        s_axi_bresp <= 2'h0;
      end else begin
        s_axi_bresp <= 2'h2;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `TPP_CTRL_RST;
    end else if (wr_go && aw_addr == `TPP_OFF_CTRL) begin
      ctrl <= (ctrl & ~lane_mask(w_strb)) |
              (w_data & lane_mask(w_strb) & `TPP_CTRL_MASK);
    end
  end

  // Thresholds come from nonvolatile storage through software writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh <= `TPP_THRESH_RST;
    end else if (wr_go && aw_addr == `TPP_OFF_THRESH) begin
      thresh <= (thresh & ~lane_mask(w_strb)) |
                (w_data & lane_mask(w_strb) & `TPP_THRESH_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= `TPP_INT_RST;
    end else if (wr_go && aw_addr == `TPP_OFF_INT_MASK && w_strb[0]) begin
      int_mask <= w_data[`TPP_INT_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign int_set = {ev_pci_stop, ctl.ev_spin, ctl.ev_critical,
                    ctl.ev_throttle, ctl.ev_manage};
  assign int_clr = (wr_go && aw_addr == `TPP_OFF_INT_STAT && w_strb[0]) ?
                   w_data[`TPP_INT_BITS-1:0] : `TPP_INT_RST;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= `TPP_INT_RST;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      if (s_axi_araddr == `TPP_OFF_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == `TPP_OFF_THRESH) begin
        s_axi_rdata <= thresh;
      end else if (s_axi_araddr == `TPP_OFF_STATUS) begin
        s_axi_rdata <= {8'h00, ctl.temp, 4'h0, ctl.therm_state,
                        2'h0, pci_clk_enable, hdd_spin_down,
                        critical_suspend_req, stop_clock_request,
                        audio_low_power, fan_enable};
      end else if (s_axi_araddr == `TPP_OFF_INT_STAT) begin
        s_axi_rdata <= {27'h0, int_stat};
      end else if (s_axi_araddr == `TPP_OFF_INT_MASK) begin
        s_axi_rdata <= {27'h0, int_mask};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Engines
  // ----------------------------------------------------------------
  assign ctl.temp         = processor_temperature_sense;
  assign ctl.thr_low      = thresh[7:0];
  assign ctl.thr_mid      = thresh[15:8];
  assign ctl.thr_high     = thresh[23:16];
  assign ctl.drive_active = drive_activity;
  assign ctl.spin_sel     = ctrl[`TPP_CTRL_SPIN_LSB+2:`TPP_CTRL_SPIN_LSB];

  tpp_thermal #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .THROTTLE_HALF (THROTTLE_HALF)
  ) u_thermal (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl.therm)
  );

  tpp_idle_timer #(
    .TICK_CYCLES (SPIN_TICK_CYCLES)
  ) u_idle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (ctl.idle)
  );

  // ----------------------------------------------------------------
  // Power state gating
  // ----------------------------------------------------------------
  assign pstate    = tpp_pkg::tpp_pstate_t'(
                       ctrl[`TPP_CTRL_STATE_LSB+2:`TPP_CTRL_STATE_LSB]);
  assign audio_off = pstate == tpp_pkg::TPP_PS_STANDBY ||
                     pstate == tpp_pkg::TPP_PS_SUSPEND ||
                     ctrl[`TPP_CTRL_AUDIO_DIS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fan_enable           <= 1'b0;
      stop_clock_request   <= 1'b0;
      critical_suspend_req <= 1'b0;
      l2_cache_power_en    <= 1'b1;
      hdd_power_en         <= 1'b1;
      bay_power_en         <= 1'b1;
      hdd_spin_down        <= 1'b0;
      super_io_low_power   <= 1'b0;
      audio_low_power      <= 1'b0;
      general_output_3     <= 1'b0;
    end else begin
      fan_enable           <= ctl.fan_on;
      // Standby parks the core in stop-clock; otherwise throttle pulses.
      stop_clock_request   <= ctl.stop_clk ||
                              pstate == tpp_pkg::TPP_PS_STANDBY;
      critical_suspend_req <= ctl.therm_state ==
                              tpp_pkg::TPP_TH_CRITICAL;
      l2_cache_power_en    <= !(pstate == tpp_pkg::TPP_PS_OFF ||
                                pstate == tpp_pkg::TPP_PS_SUSPEND);
      hdd_power_en         <= pstate != tpp_pkg::TPP_PS_STANDBY;
      bay_power_en         <= pstate != tpp_pkg::TPP_PS_STANDBY;
      hdd_spin_down        <= ctl.spun_down;
      super_io_low_power   <= pstate == tpp_pkg::TPP_PS_STANDBY ||
                              pstate == tpp_pkg::TPP_PS_STATIC;
      audio_low_power      <= audio_off;
      general_output_3     <= audio_off;
    end
  end

  assign amp_powerdown = general_output_3;

  // ----------------------------------------------------------------
  // PCI clock-run control
  // ----------------------------------------------------------------
  // The pin is released before stopping so an agent may hold it low and
  // veto the stop; a low level while stopped restarts the clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cr_state    <= tpp_pkg::TPP_CR_RUN;
      idle_cnt    <= 8'h00;
      ev_pci_stop <= 1'b0;
    end else begin
      ev_pci_stop <= 1'b0;
      case (cr_state)
        tpp_pkg::TPP_CR_RUN: begin
          if (pci_activity) begin
            idle_cnt <= 8'h00;
          end else if (idle_cnt == 8'(CLKRUN_IDLE_CYC - 1)) begin
            idle_cnt <= 8'h00;
            cr_state <= tpp_pkg::TPP_CR_RELEASE;
          end else begin
            idle_cnt <= idle_cnt + 8'h01;
          end
        end
        tpp_pkg::TPP_CR_RELEASE: begin
          if (clkrun_n_in && !pci_activity) begin
            cr_state    <= tpp_pkg::TPP_CR_STOPPED;
            ev_pci_stop <= 1'b1;
          end else begin
            cr_state <= tpp_pkg::TPP_CR_RUN;
          end
        end
        tpp_pkg::TPP_CR_STOPPED: begin
          if (!clkrun_n_in || pci_activity) begin
            cr_state <= tpp_pkg::TPP_CR_RUN;
          end
        end
        default: begin
          cr_state <= tpp_pkg::TPP_CR_RUN;
        end
      endcase
    end
  end

  assign clkrun_n_out   = 1'b0;
  assign clkrun_n_oe    = (cr_state == tpp_pkg::TPP_CR_RUN);
  assign pci_clk_enable = (cr_state != tpp_pkg::TPP_CR_STOPPED);

endmodule

/* File: test/tpp_partner.sv */
// Clock-run pin with its pull-up, as seen from the chipset side.
`timescale 1ns/1ns
module tpp_partner (
  input  wire logic clkrun_n_out, // Level the block drives.
  input  wire logic clkrun_n_oe,  // High while the block drives.
  output logic      clkrun_n_in   // Resolved pin level.
);
  // The pull-up wins whenever nobody pulls low.
  assign clkrun_n_in = (clkrun_n_oe && !clkrun_n_out) ? 1'b0 : 1'b1;
endmodule

/* File: test/tpp_checker.sv */
// Concurrent checks on the thermal and power policy top ports.
`timescale 1ns/1ns
module tpp_checker (
  input wire logic aclk, aresetn, fan_enable, critical_suspend_req,
  input wire logic pci_activity, pci_clk_enable, clkrun_n_oe,
  input wire logic drive_activity, hdd_spin_down, hdd_power_en,
  input wire logic bay_power_en, l2_cache_power_en, super_io_low_power,
  input wire logic audio_low_power, general_output_3, amp_powerdown
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wake;
    pci_activity && !pci_clk_enable;
  endsequence
  property p_wake; s_wake |-> ##[1:3] pci_clk_enable; endproperty
  property p_stop; $fell(pci_clk_enable) |-> !$past(clkrun_n_oe); endproperty
  property p_amp; amp_powerdown == general_output_3; endproperty
  property p_gpo; $rose(audio_low_power) |-> ##[0:2] general_output_3;
  endproperty
  property p_fan; critical_suspend_req |-> fan_enable; endproperty
  property p_spin; drive_activity |-> ##2 !hdd_spin_down; endproperty
  property p_bay; hdd_power_en == bay_power_en; endproperty
  property p_sio; !hdd_power_en && l2_cache_power_en |-> super_io_low_power;
  endproperty
  a_wake: assert property (p_wake) else $error("clock not restarted");
  a_stop: assert property (p_stop) else $error("stop without release");
  a_amp: assert property (p_amp) else $error("amp copy wrong");
  a_gpo: assert property (p_gpo) else $error("amp not down");
  a_fan: assert property (p_fan) else $error("fan off");
  a_spin: assert property (p_spin) else $error("still spun down");
  a_bay: assert property (p_bay) else $error("bay differs");
  a_sio: assert property (p_sio) else $error("super io awake");
endmodule

/* File: test/tpp_top_tb.sv */
// Self-checking bench for the thermal and power policy top.
`timescale 1ns/1ns
module tpp_top_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_rvalid, s_axi_awready, s_axi_wready;
  logic        s_axi_arready, s_axi_bready, s_axi_rready, drive_activity;
  logic        pci_activity, clkrun_n_in, clkrun_n_out, clkrun_n_oe, irq;
  logic        pci_clk_enable, fan_enable, stop_clock_request, hdd_power_en;
  logic        critical_suspend_req, l2_cache_power_en, bay_power_en;
  logic        hdd_spin_down, super_io_low_power, audio_low_power;
  logic        general_output_3, amp_powerdown, tb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, processor_temperature_sense;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          n_mismatch, total_checks;
  logic [7:0]  pc [6] = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h10, 8'h00};
  logic [5:0]  pe [6] = '{6'h27, 6'h04, 6'h03, 6'h00, 6'h3b, 6'h38};
  logic [5:0]  pm [6] = '{6'h3f, 6'h04, 6'h23, 6'h20, 6'h3f, 6'h3f};
  logic [7:0]  tv [7] = '{8'd60, 8'd90, 8'd96, 8'd67, 8'd65, 8'd67, 8'd70};
  logic [3:0]  sv [7] = '{4'h1, 4'h4, 4'h8, 4'h2, 4'h1, 4'h1, 4'h2};
  tpp_top #(.SAMPLE_CYCLES(16), .SPIN_TICK_CYCLES(4)) uut (.*);
  tpp_partner far (.*);
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Readies and answers are read at the edge, as the design samples them.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      {tb, r} = {s_axi_bvalid, s_axi_bresp};
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      {tb, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
    end while (!tb);
    chk(d & m, e);
  endtask
  task automatic t_regs;
    rd(8'h04, 32'hffffffff, 32'h005f5546);
    rd(8'h20, 32'h0, 32'h0);
    chk(r, 2'b10);
    wr(8'h24, 32'h1);
    chk(r, 2'b10);
    $display("register test done");
  endtask
  task automatic t_power;
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {24'h0, pc[i]});
      cyc(3);
      rd(8'h00, 32'hffffffff, {24'h0, pc[i]});
      chk({l2_cache_power_en, hdd_power_en, bay_power_en, super_io_low_power,
           audio_low_power, amp_powerdown} & pm[i], pe[i]);
    end
    $display("power state test done");
  endtask
  task automatic t_therm;
    for (int i = 0; i < 7; i++) begin
      processor_temperature_sense <= tv[i];
      cyc(40);
      rd(8'h08, 32'hf00, {20'h0, sv[i], 8'h0});
      chk({fan_enable, critical_suspend_req}, {sv[i] != 1, sv[i] == 8});
      if (sv[i] == 4'h8) begin
        cyc(500);
        chk(stop_clock_request, 1'b1);
        cyc(500);
        chk(stop_clock_request, 1'b0);
      end
    end
    rd(8'h0c, 32'h7, 32'h7);
    chk(irq, 1'b0);
    wr(8'h10, 32'h1);
    cyc(3);
    chk(irq, 1'b1);
    wr(8'h0c, 32'h7);
    cyc(3);
    chk(irq, 1'b0);
    $display("thermal test done");
  endtask
  task automatic t_link;
    wr(8'h10, 32'h8);
    drive_activity <= 1'b1;
    wr(8'h00, 32'h100);
    drive_activity <= 1'b0;
    cyc(200);
    chk({hdd_spin_down, irq}, 2'b00);
    cyc(60);
    chk({hdd_spin_down, irq}, 2'b11);
    drive_activity <= 1'b1;
    cyc(3);
    drive_activity <= 1'b0;
    chk(hdd_spin_down, 1'b0);
    wr(8'h00, 32'h0);
    cyc(300);
    chk(hdd_spin_down, 1'b0);
    rd(8'h0c, 32'h10, 32'h10);
    pci_activity <= 1'b1;
    cyc(3);
    chk(pci_clk_enable, 1'b1);
    pci_activity <= 1'b0;
    cyc(40);
    chk(pci_clk_enable, 1'b0);
    $display("link test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    cyc(20000);
    n_mismatch++;
    results();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {drive_activity, pci_activity, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    processor_temperature_sense = 8'd60;
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    t_regs();
    t_power();
    t_therm();
    t_link();
    results();
  end
endmodule
bind tpp_top tpp_checker chk (.*);
